// ===== cbd_ahb_slave.sv
// AHB-Lite slave front end: word writes with no wait, reads with one wait.
// Assumes a single master and single whole-word transfers.
`timescale 1ns/1ps
`default_nettype none
module cbd_ahb_slave (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Bus side
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  // Register side
  output logic             regWr,
  output logic [7:0]       regAddr,
  output logic [31:0]      regWdata,
  input  wire logic [31:0] regRdata
);
  logic        take;
  logic        wrPend_q;
  logic        rdPend_q;
  logic [7:0]  addr_q;
  logic [31:0] hrdata_q;
  logic        ready_q;

  assign take = hsel & htrans[1] & hready;

  // Read data is flopped, which costs one wait state on reads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q   <= '0;
      hrdata_q <= cbd_pkg::RST_ZERO;
      ready_q  <= 1'b1;
    end else begin
      wrPend_q <= take & hwrite;
      rdPend_q <= take & ~hwrite;
      ready_q  <= ~(take & ~hwrite);
      if (take) addr_q <= haddr;
      if (rdPend_q) hrdata_q <= regRdata;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = ready_q;
  assign regWr     = wrPend_q;
  assign regAddr   = addr_q;
  assign regWdata  = hwdata;
endmodule : cbd_ahb_slave
`default_nettype wire

// ===== cbd_decoder.sv
// Command block field decoder, target side, with its register file.
// Assumes command bytes arrive at most one per cycle and executors report
// completions, accessed blocks and available data-in bytes.
`timescale 1ns/1ps
`default_nettype none
module cbd_decoder (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // AHB-Lite register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Command byte stream
  input  wire logic [7:0]  cmdByte,
  input  wire logic        cmdValid,
  input  wire logic        cmdFirst,
  output logic             cmdReady,
  // Identify message result
  input  wire logic        identifyValid,
  input  wire logic [2:0]  identifyUnit,
  // Execution feedback
  input  wire logic        accessValid,
  input  wire logic [31:0] accessLba,
  input  wire logic        cmdDone,
  input  wire logic        cmdGood,
  // Decoded command
  output logic             decValid,
  output logic [2:0]       decGroup,
  output logic [4:0]       decCode,
  output logic [2:0]       decUnit,
  output logic [31:0]      decLba,
  output logic [16:0]      decLength,
  output logic             decLenBytes,
  output logic             decParamList,
  output logic             decAlloc,
  output logic             decLink,
  output logic             decFlag,
  output logic             decIllegal,
  output logic             decSenseIllegal,
  // Data-in bounding
  input  wire logic [16:0] availBytes,
  input  wire logic        dataInStrobe,
  output logic [16:0]      dataInLimit,
  output logic             dataInStop
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] cdbLength(input logic [2:0] grp);
    case (grp)
      cbd_pkg::GRP_TEN:    cdbLength = cbd_pkg::LEN_TEN;
      cbd_pkg::GRP_TWELVE: cdbLength = cbd_pkg::LEN_TWELVE;
      default:             cdbLength = cbd_pkg::LEN_SIX;
    endcase
  endfunction : cdbLength

  function automatic logic [16:0] minLen(input logic [16:0] a, input logic [16:0] b);
    minLen = (a < b) ? a : b;
  endfunction : minLen

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic        regWr;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic [31:0] cfg_q;
  logic [31:0] maxLba_q;
  logic [31:0] alloc0_q;
  logic [31:0] alloc1_q;
  logic [31:0] param0_q;
  logic [31:0] param1_q;

  cbd_ahb_slave u_bus (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr[7:0]),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .regWr     (regWr),
    .regAddr   (regAddr),
    .regWdata  (regWdata),
    .regRdata  (regRdata)
  );

  // Only word transfers are served, so hsize is not decoded
  assign hresp = cbd_pkg::RESP_OKAY;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q    <= cbd_pkg::RST_CFG;
      maxLba_q <= cbd_pkg::RST_MAXLBA;
      alloc0_q <= cbd_pkg::RST_ZERO;
      alloc1_q <= cbd_pkg::RST_ZERO;
      param0_q <= cbd_pkg::RST_ZERO;
      param1_q <= cbd_pkg::RST_ZERO;
    end else if (regWr) begin
      case (regAddr)
        cbd_pkg::REG_CFG:    cfg_q    <= regWdata;
        cbd_pkg::REG_MAXLBA: maxLba_q <= regWdata;
        cbd_pkg::REG_ALLOC0: alloc0_q <= regWdata;
        cbd_pkg::REG_ALLOC1: alloc1_q <= regWdata;
        cbd_pkg::REG_PARAM0: param0_q <= regWdata;
        cbd_pkg::REG_PARAM1: param1_q <= regWdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte collection
  // ----------------------------------------------------------------
  cbd_pkg::cbd_state_type state_q;
  cbd_pkg::cbd_state_type state_d;
  logic [7:0]             cdb [cbd_pkg::CDB_MAX];
  logic [3:0]             idx_q;
  logic [3:0]             lastIdx;
  logic                   startByte;
  logic                   nextByte;

  assign lastIdx   = cdbLength(cdb[cbd_pkg::POS_OP][7:5]) - 4'h1;
  assign startByte = cmdValid & cmdFirst & (state_q != cbd_pkg::ST_EVAL);
  assign nextByte  = cmdValid & ~cmdFirst & (state_q == cbd_pkg::ST_COLLECT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      cbd_pkg::ST_IDLE:    if (startByte) state_d = cbd_pkg::ST_COLLECT;
      cbd_pkg::ST_COLLECT: if (nextByte && idx_q == lastIdx) state_d = cbd_pkg::ST_EVAL;
      cbd_pkg::ST_EVAL:    state_d = cbd_pkg::ST_IDLE;
      default:             state_d = cbd_pkg::ST_IDLE;
    endcase
  end

  // A new first byte restarts collection of a partial block
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= cbd_pkg::ST_IDLE;
      idx_q    <= '0;
      cmdReady <= 1'b1;
      for (int i = 0; i < cbd_pkg::CDB_MAX; i++) cdb[i] <= '0;
    end else begin
      state_q  <= state_d;
      cmdReady <= (state_d != cbd_pkg::ST_EVAL);
      if (startByte) begin
        cdb[cbd_pkg::POS_OP] <= cmdByte;
        idx_q                <= 4'h1;
      end else if (nextByte) begin
        cdb[idx_q] <= cmdByte;
        idx_q      <= idx_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [2:0]  grp;
  logic [4:0]  code;
  logic        isSix;
  logic        isTwelve;
  logic        grpBad;
  logic [7:0]  ctl;
  logic [2:0]  unit;
  logic        relFlag;
  logic [31:0] rawLba;
  logic [31:0] sixLba;
  logic [31:0] absLba;
  logic [31:0] finalLba;
  logic [31:0] baseLba;
  logic        baseValid;
  logic [15:0] wideLen;
  logic        isAlloc;
  logic        isParam;
  logic        lenBytes;
  logic [16:0] length;

  assign grp      = cdb[cbd_pkg::POS_OP][7:5];
  assign code     = cdb[cbd_pkg::POS_OP][4:0];
  assign isSix    = (grp == cbd_pkg::GRP_SIX);
  assign isTwelve = (grp == cbd_pkg::GRP_TWELVE);
  assign grpBad   = (grp >= cbd_pkg::GRP_RSV_LO && grp <= cbd_pkg::GRP_RSV_HI)
                  | (grp >= cbd_pkg::GRP_VEND_LO);
  assign ctl      = cdb[lastIdx];

  // Accepted identify unit wins over the block field
  assign unit = identifyValid ? identifyUnit
                              : cdb[cbd_pkg::POS_UNIT][7:5];

  assign relFlag = ~isSix & cdb[cbd_pkg::POS_UNIT][cbd_pkg::BIT_REL];
  assign rawLba  = {cdb[cbd_pkg::POS_LBA0], cdb[cbd_pkg::POS_LBA1],
                    cdb[cbd_pkg::POS_LBA2], cdb[cbd_pkg::POS_LBA3]};
  assign sixLba  = {11'h000, cdb[cbd_pkg::POS_UNIT][4:0],
                    cdb[cbd_pkg::POS_LBA0], cdb[cbd_pkg::POS_LBA1]};
  assign absLba  = isSix ? sixLba : rawLba;

  // Two's complement add wraps modulo 2^32, same as a signed offset
  assign finalLba = relFlag ? baseLba + rawLba : absLba;

  assign wideLen = isTwelve ? {cdb[cbd_pkg::POS_TW_LEN], cdb[cbd_pkg::POS_TW_LEN + 1]}
                            : {cdb[cbd_pkg::POS_TEN_LEN], cdb[cbd_pkg::POS_TEN_LEN + 1]};

  assign isAlloc  = isSix ? alloc0_q[code] : alloc1_q[code];
  assign isParam  = isSix ? param0_q[code] : param1_q[code];
  assign lenBytes = isAlloc | isParam;

  // Byte counts keep zero as zero; block counts on one byte do not
  assign length = ~isSix ? {1'b0, wideLen}
                : (~lenBytes && cdb[cbd_pkg::POS_SIX_LEN] == 8'h00)
                  ? cbd_pkg::LEN_SIX_ZERO
                  : {9'h000, cdb[cbd_pkg::POS_SIX_LEN]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic chainOpen_q;
  logic rsvErr;
  logic linkErr;
  logic relErr;
  logic unitErr;
  logic rangeErr;
  logic illegal;

  assign rsvErr = grpBad
                | (|ctl[5:2])
                | (~isSix & (|cdb[cbd_pkg::POS_UNIT][4:1]))
                | (~isSix & (|cdb[cbd_pkg::POS_RSV6]))
                | (isTwelve & (|cdb[cbd_pkg::POS_RSV7] | |cdb[cbd_pkg::POS_RSV8]));

  // A flag without link is refused; link needs linking enabled
  assign linkErr = (ctl[cbd_pkg::BIT_FLAG] & ~ctl[cbd_pkg::BIT_LINK])
                 | ((ctl[cbd_pkg::BIT_LINK] | ctl[cbd_pkg::BIT_FLAG])
                    & ~cfg_q[cbd_pkg::CFG_LINK_EN]);

  // Never compute from a stale base: need an open chain and a fresh access
  assign relErr = relFlag & ~(chainOpen_q & baseValid);

  assign unitErr  = ~cfg_q[cbd_pkg::CFG_UNIT_LO + unit];
  assign rangeErr = finalLba > maxLba_q;
  assign illegal  = rsvErr | linkErr | relErr | unitErr | rangeErr;

  // ----------------------------------------------------------------
  // Chain tracking and last accessed block
  // ----------------------------------------------------------------
  logic chainEnd;
  logic curLink_q;

  assign chainEnd = cmdDone & (~cmdGood | ~curLink_q);

  cbd_lba_store #(
    .UNITS (8)
  ) u_store (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wrEn     (accessValid),
    .wrUnit   (decUnit),
    .wrLba    (accessLba),
    .clrAll   (chainEnd),
    .rdUnit   (unit),
    .rdLba    (baseLba),
    .rdValid  (baseValid)
  );

  // A chain opens on an accepted linked command
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chainOpen_q <= 1'b0;
      curLink_q   <= 1'b0;
    end else if (state_q == cbd_pkg::ST_EVAL) begin
      curLink_q   <= ctl[cbd_pkg::BIT_LINK] & ~illegal;
      chainOpen_q <= chainOpen_q | (ctl[cbd_pkg::BIT_LINK] & ~illegal);
    end else if (chainEnd) begin
      chainOpen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  logic eval;

  assign eval = (state_q == cbd_pkg::ST_EVAL);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      decValid        <= 1'b0;
      decGroup        <= '0;
      decCode         <= '0;
      decUnit         <= '0;
      decLba          <= '0;
      decLength       <= '0;
      decLenBytes     <= 1'b0;
      decParamList    <= 1'b0;
      decAlloc        <= 1'b0;
      decLink         <= 1'b0;
      decFlag         <= 1'b0;
      decIllegal      <= 1'b0;
      decSenseIllegal <= 1'b0;
    end else begin
      decValid <= eval;
      if (eval) begin
        decGroup        <= grp;
        decCode         <= code;
        decUnit         <= unit;
        decLba          <= finalLba;
        decLength       <= length;
        decLenBytes     <= lenBytes;
        decParamList    <= isParam;
        decAlloc        <= isAlloc;
        decLink         <= ctl[cbd_pkg::BIT_LINK];
        decFlag         <= ctl[cbd_pkg::BIT_FLAG];
        decIllegal      <= illegal;
        decSenseIllegal <= illegal & cfg_q[cbd_pkg::CFG_EXT_SNS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Data-in bounding
  // ----------------------------------------------------------------
  logic        dinActive_q;
  logic [16:0] allocLen_q;
  logic [16:0] dinCount_q;
  logic [16:0] dinCount_d;
  logic [16:0] limit;

  assign limit      = minLen(allocLen_q, availBytes);
  assign dinCount_d = dinCount_q + {16'h0000, dataInStrobe};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dinActive_q <= 1'b0;
      allocLen_q  <= '0;
      dinCount_q  <= '0;
      dataInLimit <= '0;
      dataInStop  <= 1'b0;
    end else begin
      dataInLimit <= limit;
      if (eval) begin
        dinActive_q <= isAlloc & ~illegal;
        allocLen_q  <= length;
        dinCount_q  <= '0;
        dataInStop  <= 1'b0;
      end else if (dinActive_q) begin
        dinCount_q <= dinCount_d;
        dataInStop <= dinCount_d >= limit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] statWord;

  assign statWord = {13'h0000, decIllegal, decSenseIllegal, decLenBytes, decParamList,
                     decAlloc, decLink, decFlag, chainOpen_q, decUnit, decGroup, decCode};

  assign regRdata = (regAddr == cbd_pkg::REG_CFG)    ? cfg_q
                  : (regAddr == cbd_pkg::REG_MAXLBA) ? maxLba_q
                  : (regAddr == cbd_pkg::REG_ALLOC0) ? alloc0_q
                  : (regAddr == cbd_pkg::REG_ALLOC1) ? alloc1_q
                  : (regAddr == cbd_pkg::REG_PARAM0) ? param0_q
                  : (regAddr == cbd_pkg::REG_PARAM1) ? param1_q
                  : (regAddr == cbd_pkg::REG_STAT)   ? statWord
                  : (regAddr == cbd_pkg::REG_LBA)    ? decLba
                  : (regAddr == cbd_pkg::REG_LEN)    ? {15'h0000, decLength}
                  : cbd_pkg::RST_ZERO;
endmodule : cbd_decoder
`default_nettype wire

// ===== cbd_decoder_asserts.sv
// Checker for decoder output timing and field rules.
// Assumes binding to cbd_decoder; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cbd_decoder_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Decoder side
  input wire logic        cmdReady,
  input wire logic        decValid,
  input wire logic [2:0]  decGroup,
  input wire logic [31:0] decLba,
  input wire logic [16:0] decLength,
  input wire logic        decLenBytes,
  input wire logic        decAlloc,
  input wire logic        decLink,
  input wire logic        decFlag,
  input wire logic        decIllegal,
  input wire logic [16:0] availBytes,
  input wire logic [16:0] dataInLimit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_eval_first: assert property (decValid |-> !$past(cmdReady))
    else $error("decode without eval cycle");
  a_ready_back: assert property (!cmdReady |=> cmdReady && decValid)
    else $error("eval cycle not one cycle");
  a_rsv_group: assert property (decValid && decGroup inside {[2:4], [6:7]} |-> decIllegal)
    else $error("reserved group accepted");
  a_short_addr: assert property (decValid && decGroup == 3'h0 |-> decLba[31:21] == 11'h000)
    else $error("six-byte address too wide");
  a_flag_link: assert property (decValid && decFlag && !decLink |-> decIllegal)
    else $error("flag without link accepted");
  // Availability is held by the bench across the window
  a_alloc_min: assert property (decValid && decAlloc ##1 $stable(availBytes) |=>
    dataInLimit == (decLength < availBytes ? decLength : availBytes))
    else $error("data-in limit wrong");
  a_one_byte: assert property (decValid && decGroup == 3'h0 && !decLenBytes |->
    decLength != 17'h0_0000)
    else $error("one-byte zero length kept");
  a_two_byte: assert property (decValid && decGroup != 3'h0 |-> !decLength[16])
    else $error("two-byte length too wide");
endmodule : cbd_decoder_asserts
bind cbd_decoder cbd_decoder_asserts u_chk (.core_clk, .reset_n, .cmdReady, .decValid,
  .decGroup, .decLba, .decLength, .decLenBytes, .decAlloc, .decLink, .decFlag, .decIllegal,
  .availBytes, .dataInLimit);
`default_nettype wire

// ===== cbd_initiator.sv
// Initiator model: sends one command block, byte 0 first.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`default_nettype none
module cbd_initiator (
  // Clock and block to send
  input wire logic        core_clk,
  input wire logic        start,
  input wire logic        slow,
  input wire logic [95:0] blk,
  input wire logic [3:0]  len,
  // Byte stream
  output logic [7:0]      cmdByte = 8'h00,
  output logic            cmdValid = 1'b0,
  output logic            cmdFirst = 1'b0
);
  logic [3:0]  idx = 4'h0;
  logic [95:0] sh;
  always @(posedge core_clk) begin
    if (start) begin
      idx <= len;
      sh  <= blk;
    end else if (idx != 4'h0 && !(slow && cmdValid)) begin
      cmdByte  <= sh[95:88]; // Most significant byte first
      cmdFirst <= (idx == len);
      cmdValid <= 1'b1;
      sh       <= sh << 8;
      idx      <= idx - 4'h1;
    end else begin
      cmdValid <= 1'b0;
      cmdFirst <= 1'b0;
      cmdByte  <= ~cmdByte; // Idle line alternates between the last byte and its inverse
    end
  end
endmodule : cbd_initiator
`default_nettype wire

// ===== cbd_lba_store.sv
// Per-unit store of the last accessed block address within a chain.
// Assumes the owner clears it whenever a linked chain ends.
`timescale 1ns/1ps
`default_nettype none
module cbd_lba_store #(
  parameter int UNITS = 8
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Update port
  input  wire logic                     wrEn,
  input  wire logic [2:0]               wrUnit,
  input  wire logic [cbd_pkg::LBA_W-1:0] wrLba,
  input  wire logic                     clrAll,
  // Lookup port
  input  wire logic [2:0]               rdUnit,
  output logic [cbd_pkg::LBA_W-1:0]     rdLba,
  output logic                          rdValid
);
  if (UNITS != 8) $error("cbd_lba_store: unit field serves exactly 8 units");

  logic [cbd_pkg::LBA_W-1:0] lastLba [UNITS];
  logic [UNITS-1:0]          valid_q;

  // A write in the clearing cycle still survives so that no access is lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= '0;
    end else begin
      if (clrAll) valid_q <= '0;
      if (wrEn) valid_q[wrUnit] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrEn) lastLba[wrUnit] <= wrLba;
  end

  assign rdLba   = lastLba[rdUnit];
  assign rdValid = valid_q[rdUnit];
endmodule : cbd_lba_store
`default_nettype wire

// ===== cbd_pkg.sv
// Constants, register map and types for the command block decoder.
// Assumes one 100 MHz clock and AHB-Lite register access.
package cbd_pkg;

  // ----------------------------------------------------------------
  // Command block layout
  // ----------------------------------------------------------------
  localparam int         CDB_MAX      = 12;
  localparam int         IDX_W        = 4;
  localparam logic [2:0] GRP_SIX      = 3'h0;
  localparam logic [2:0] GRP_TEN      = 3'h1;
  localparam logic [2:0] GRP_TWELVE   = 3'h5;
  localparam logic [2:0] GRP_RSV_LO   = 3'h2;
  localparam logic [2:0] GRP_RSV_HI   = 3'h4;
  localparam logic [2:0] GRP_VEND_LO  = 3'h6;
  localparam logic [3:0] LEN_SIX      = 4'h6;
  localparam logic [3:0] LEN_TEN      = 4'hA;
  localparam logic [3:0] LEN_TWELVE   = 4'hC;
  localparam int         POS_OP       = 0;
  localparam int         POS_UNIT     = 1;
  localparam int         POS_LBA0     = 2;
  localparam int         POS_LBA1     = 3;
  localparam int         POS_LBA2     = 4;
  localparam int         POS_LBA3     = 5;
  localparam int         POS_SIX_LEN  = 4;
  localparam int         POS_RSV6     = 6;
  localparam int         POS_RSV7     = 7;
  localparam int         POS_RSV8     = 8;
  localparam int         POS_TEN_LEN  = 7;
  localparam int         POS_TW_LEN   = 9;
  localparam int         BIT_REL      = 0;
  localparam int         BIT_LINK     = 0;
  localparam int         BIT_FLAG     = 1;
  localparam int         LBA_W        = 32;
  localparam int         LEN_W        = 17;
  localparam logic [16:0] LEN_SIX_ZERO = 17'h0_0100;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CFG     = 8'h00;
  localparam logic [7:0]  REG_MAXLBA  = 8'h04;
  localparam logic [7:0]  REG_ALLOC0  = 8'h08;
  localparam logic [7:0]  REG_ALLOC1  = 8'h0C;
  localparam logic [7:0]  REG_PARAM0  = 8'h10;
  localparam logic [7:0]  REG_PARAM1  = 8'h14;
  localparam logic [7:0]  REG_STAT    = 8'h20;
  localparam logic [7:0]  REG_LBA     = 8'h24;
  localparam logic [7:0]  REG_LEN     = 8'h28;
  localparam logic [31:0] RST_CFG     = 32'h0000_0103;
  localparam logic [31:0] RST_MAXLBA  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam int          CFG_LINK_EN = 0;
  localparam int          CFG_EXT_SNS = 1;
  localparam int          CFG_UNIT_LO = 8;
  localparam logic        RESP_OKAY   = 1'b0;

  typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_EVAL} cbd_state_type;

endpackage : cbd_pkg

// ===== testbench.sv
// Self-checking bench for the command block decoder.
// Assumes cbd_initiator as far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, slow = 1'b0;
  logic idV = 1'b0, accV = 1'b0, done = 1'b0, good = 1'b0, strb = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] idU = 3'h0;
  logic [3:0] len = 4'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = '0, accLba = '0, rd;
  logic [95:0] blk = '0;
  wire logic [7:0] cmdByte;
  wire logic [2:0] dG, dU;
  wire logic [4:0] dC;
  wire logic [31:0] hrdata, dL;
  wire logic [16:0] dN, lim;
  wire logic cmdValid, cmdFirst, cmdReady, hreadyout, hresp, decValid, dB, dI, stop;
  int err_count = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  cbd_initiator u_ini (.core_clk, .start, .slow, .blk, .len, .cmdByte, .cmdValid, .cmdFirst);
  cbd_decoder dut (.core_clk, .reset_n, .hsel, .haddr({24'h0, haddr}), .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cmdByte,
    .cmdValid, .cmdFirst, .cmdReady, .identifyValid(idV), .identifyUnit(idU),
    .accessValid(accV), .accessLba(accLba), .cmdDone(done), .cmdGood(good), .decValid,
    .decGroup(dG), .decCode(dC), .decUnit(dU), .decLba(dL), .decLength(dN), .decLenBytes(dB),
    .decParamList(), .decAlloc(), .decLink(), .decFlag(), .decIllegal(dI), .decSenseIllegal(),
    .availBytes(17'h0_0032), .dataInStrobe(strb), .dataInLimit(lim), .dataInStop(stop));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic hold(logic sel);
    int i = 0;
    do @(posedge core_clk); while ((sel ? decValid : hreadyout) !== 1'b1 && ++i < 60);
    if (i >= 60) begin
      err_count++;
      results();
    end
  endtask : hold
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hold(1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    hold(1'b0);
    rd = hrdata;
  endtask : bus
  task automatic send(logic [95:0] b, logic [3:0] n);
    blk <= b;
    len <= n;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    hold(1'b1);
  endtask : send
  task automatic t_regs();
    bus(1'b0, cbd_pkg::REG_CFG, '0);
    chk("cfg", cbd_pkg::RST_CFG, rd);
    chk("resp", 32'h0, hresp);
    bus(1'b0, 8'h40, '0);
    chk("unmapped", '0, rd);
    bus(1'b1, cbd_pkg::REG_CFG, 32'h0000_FF03);
    bus(1'b1, cbd_pkg::REG_ALLOC0, 32'h0000_0008);
    bus(1'b1, cbd_pkg::REG_PARAM0, 32'h0000_0002);
    bus(1'b0, cbd_pkg::REG_CFG, '0);
    chk("cfgwr", 32'h0000_FF03, rd);
  endtask : t_regs
  task automatic t_layout();
    slow <= 1'b1;
    send({8'h28, 8'h40, 32'h0001_0203, 24'h00_0010, 24'h0}, 4'hA);
    chk("grp", 32'h1, dG);
    chk("code", 32'h8, dC);
    chk("unit", 32'h2, dU);
    chk("lba", 32'h0001_0203, dL);
    chk("len", 32'h10, dN);
    slow <= 1'b0;
    send({8'hA8, 8'hE0, 32'hFFFF_FFF0, 48'h0}, 4'hC);
    chk("lba12", 32'hFFFF_FFF0, dL);
    chk("len12", 32'h0, dN);
    send({8'h08, 8'h3F, 32'hFFFF_0000, 48'h0}, 4'h6);
    chk("lba6", 32'h001F_FFFF, dL);
    chk("len6", 32'h100, dN);
  endtask : t_layout
  task automatic t_ident();
    idV <= 1'b1;
    idU <= 3'h5;
    send({8'h28, 8'h40, 80'h0}, 4'hA);
    chk("idunit", 32'h5, dU);
    send({8'h28, 8'hA0, 80'h0}, 4'hA);
    chk("sameunit", 32'h5, dU);
    idV <= 1'b0;
  endtask : t_ident
  task automatic t_rsv();
    send({8'h28, 8'h00, 32'h0, 8'h01, 40'h0}, 4'hA);
    chk("rsvbyte", 32'h1, dI);
    for (int g = 2; g < 8; g++) if (g != 5) begin
      send({g[2:0], 5'h00, 88'h0}, 4'h6);
      chk("rsvgrp", 32'h1, dI);
    end
    send({8'h01, 8'h00, 24'h0, 8'h02, 48'h0}, 4'h6);
    chk("paramlen", 32'h0, dN);
    chk("flagonly", 32'h1, dI);
    bus(1'b0, cbd_pkg::REG_STAT, '0);
    chk("stat", 32'h0007_9001, rd);
  endtask : t_rsv
  task automatic t_rel();
    send({8'h28, 8'h01, 32'h0000_0064, 48'h0}, 4'hA);
    chk("nobase", 32'h1, dI);
    send({8'h28, 8'h00, 32'h0000_0064, 24'h0, 8'h01, 16'h0}, 4'hA);
    accV <= 1'b1;
    accLba <= 32'h0000_0064;
    done <= 1'b1;
    good <= 1'b1;
    @(posedge core_clk);
    {accV, done} <= 2'b00;
    send({8'h28, 8'h01, 32'hFFFF_FFFE, 24'h0, 8'h01, 16'h0}, 4'hA);
    chk("rel", 32'h0000_0062, dL);
    chk("relok", 32'h0, dI);
    bus(1'b0, cbd_pkg::REG_STAT, '0);
    chk("statrel", 32'h0000_2828, rd);
  endtask : t_rel
  task automatic t_alloc();
    send({8'h03, 8'h00, 16'h0, 8'h14, 56'h0}, 4'h6);
    chk("bytes", 32'h1, dB);
    repeat (19) begin
      strb <= 1'b1;
      @(posedge core_clk);
    end
    strb <= 1'b0;
    @(posedge core_clk);
    chk("lim", 32'h14, lim);
    chk("early", 32'h0, stop);
    strb <= 1'b1;
    @(posedge core_clk);
    strb <= 1'b0;
    @(posedge core_clk);
    chk("stop", 32'h1, stop);
  endtask : t_alloc
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_layout();
    t_ident();
    t_rsv();
    t_rel();
    t_alloc();
    results();
  end
endmodule : testbench
`default_nettype wire
